// ===== core/keyed_watchdog_timer.sv
// Purpose: 64-bit timer with keyed watchdog mode and register port
// Assumes: Registers reached by address, write/read strobes, read data next cycle
// Notes:   One clock; counter advances once per clock when enabled
// What this block does
// - Watchdog runs only with mode field 2h and enable bit set.
// - Halves join to 64-bit count and period; match resets the processor.
// - Active watchdog leaves only by timeout or hardware reset.
// - Service is A5C6h then DA7Eh written to the key field.
// - Any other key value written while active times out at once.
// - Timeout clears enable bit, stops watchdog and resets the counter.
// - After timeout, enable writes do nothing until hardware reset.
// - After hardware reset watchdog is off, registers freely accessible.
// - Enable set plus key A5C6h moves Initial to Pre-active.
// - Pre-active control writes taken only with a valid key.
// - Pre-active DA7Eh with enable set clears counters, goes Active.
// - Each completed service sequence clears the counter to zero.
// - From Pre-active, counter, period and GCR mode field writes ignored; run bits and TCR still taken.
// - Watchdog never enters power-down.
// - Cleared run bit holds that half's counter.
// - Host-side emulator reset restores defaults only before Pre-active; other side changes nothing.
// - Hardware reset loads every register with its default.
// - Period match pulses interrupt and DMA event, never in watchdog mode.
// - Suspend: both zero stops, soft stops at period, free runs.
// - Counter advances once per peripheral clock during emulation suspend only with free set, or with soft set until period.
// - Watchdog uses internal clock only, never one-time enabling.
`timescale 1ns/1ns
`include "keyed_watchdog_timer_consts.svh"
module keyed_watchdog_timer
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        susp_host,
    input  wire logic        susp_dsp,
    input  wire logic        suspend_source_select,
    input  wire logic        emu_reset_host,
    input  wire logic        idle_req,
    output logic             idle_ack,
    output logic             timer_interrupt_line,
    output logic             timer_dma_event,
    output logic             processor_reset_req
);

    // ------------------------------------------------------------------
    // State and next values
    // ------------------------------------------------------------------
    logic                   emu_free, next_emu_free;
    logic                   emu_soft, next_emu_soft;
    logic [63:0]            prd, next_prd;
    logic [1:0]             en_mode, next_en_mode;
    logic                   run_lo, next_run_lo;
    logic                   run_hi, next_run_hi;
    logic [1:0]             tmode, next_tmode;
    logic                   wd_en, next_wd_en;
    logic [15:0]            wd_key, next_wd_key;
    logic                   armed, next_armed;
    watchdog_pkg::wd_state_t state, next_state;
    logic [31:0]            next_rdata;
    logic                   next_irq, next_dma, next_prst, next_idle_ack;

    logic [15:0]            wr_key;
    logic                   key_ok, wd_mode, locked, emu_rst, susp;
    logic                   match, count_en, gp_run, wd_run, clear_cnt;
    logic                   wdcr_wr, new_en;
    logic [31:0]            rd_wdcr;
    logic [63:0]            count;

    half_if #(.W(32)) lo_if ();
    half_if #(.W(32)) hi_if ();

    // ------------------------------------------------------------------
    // Counter halves
    // ------------------------------------------------------------------
    counter_half #(.W(32)) u_lo (.clk(clk), .rst_b(rst_b), .hf(lo_if.half));
    counter_half #(.W(32)) u_hi (.clk(clk), .rst_b(rst_b), .hf(hi_if.half));

    assign count = {hi_if.value, lo_if.value};

    // Decode, run conditions and next register values
    always_comb
    begin
        next_emu_free = emu_free;
        next_emu_soft = emu_soft;
        next_prd      = prd;
        next_en_mode  = en_mode;
        next_run_lo   = run_lo;
        next_run_hi   = run_hi;
        next_tmode    = tmode;
        next_wd_en    = wd_en;
        next_wd_key   = wd_key;
        next_armed    = armed;
        next_state    = state;
        next_prst     = 1'b0;
        clear_cnt     = 1'b0;
        wr_key   = wdata[`WD_KEY_LSB +: 16];
        new_en   = wdata[`WD_EN_BIT];
        key_ok   = (wr_key == `KEY_FIRST) || (wr_key == `KEY_SECOND);
        wd_mode  = (tmode == `MODE_WATCHDOG);
        wdcr_wr  = wr && (addr == `OFF_WDCR);
        locked   = (state == watchdog_pkg::WD_PREACTIVE) ||
                   (state == watchdog_pkg::WD_ACTIVE) ||
                   (state == watchdog_pkg::WD_TIMEOUT);
        emu_rst  = emu_reset_host && !locked;
        susp     = suspend_source_select ? susp_dsp : susp_host;
        match    = (count == prd) && (prd != `RST_PRD);
        count_en = !(susp && !emu_free && (!emu_soft || match));
        gp_run   = !wd_mode && (en_mode != `EN_OFF) && count_en;
        wd_run   = wd_mode && (state == watchdog_pkg::WD_ACTIVE) && count_en;
        // Period match in general-purpose mode
        next_irq = gp_run && match;
        next_dma = gp_run && match;
        if (gp_run && match)
        begin
            if (en_mode == `EN_ONCE)
                next_en_mode = `EN_OFF;
            else
                clear_cnt = 1'b1;
        end
        // Plain register writes
        if (wr)
        begin
            case (addr)
                `OFF_EMU:
                begin
                    next_emu_free = wdata[`EMU_FREE_BIT];
                    next_emu_soft = wdata[`EMU_SOFT_BIT];
                end
                `OFF_PRD_LO: if (!locked) next_prd[31:0] = wdata;
                `OFF_PRD_HI: if (!locked) next_prd[63:32] = wdata;
                `OFF_TCR:    next_en_mode = wdata[`TCR_EN_LSB +: 2];
                `OFF_GCR:
                begin
                    next_run_lo = wdata[`GCR_RUN_LO_BIT];
                    next_run_hi = wdata[`GCR_RUN_HI_BIT];
                    if (!locked)
                        next_tmode = wdata[`GCR_MODE_LSB +: 2];
                end
                default: ;
            endcase
        end
        // Watchdog key state machine
        case (state)
            watchdog_pkg::WD_DISABLED, watchdog_pkg::WD_INITIAL:
            begin
                if (wdcr_wr)
                begin
                    next_wd_en  = new_en;
                    next_wd_key = wr_key;
                end
                if (!wd_mode)
                    next_state = watchdog_pkg::WD_DISABLED;
                else if (state == watchdog_pkg::WD_DISABLED)
                    next_state = watchdog_pkg::WD_INITIAL;
                else if (wdcr_wr && new_en && wr_key == `KEY_FIRST)
                    next_state = watchdog_pkg::WD_PREACTIVE;
            end
            watchdog_pkg::WD_PREACTIVE:
            begin
                if (wdcr_wr && key_ok)
                begin
                    next_wd_en  = new_en;
                    next_wd_key = wr_key;
                    if (wr_key == `KEY_SECOND && new_en)
                    begin
                        clear_cnt  = 1'b1;
                        next_armed = 1'b0;
                        next_state = watchdog_pkg::WD_ACTIVE;
                    end
                end
            end
            watchdog_pkg::WD_ACTIVE:
            begin
                if (wdcr_wr)
                begin
                    next_wd_key = wr_key;
                    if (wr_key == `KEY_FIRST)
                        next_armed = 1'b1;
                    else if (wr_key == `KEY_SECOND)
                    begin
                        if (armed)
                            clear_cnt = 1'b1;
                        next_armed = 1'b0;
                    end
                    else
                        next_state = watchdog_pkg::WD_TIMEOUT;
                end
                if (wd_run && match)
                    next_state = watchdog_pkg::WD_TIMEOUT;
                if (next_state == watchdog_pkg::WD_TIMEOUT)
                begin
                    next_wd_en = 1'b0;
                    next_armed = 1'b0;
                    clear_cnt  = 1'b1;
                    next_prst  = 1'b1;
                end
            end
            watchdog_pkg::WD_TIMEOUT:
            begin
                next_wd_en = 1'b0;
            end
            default: next_state = watchdog_pkg::WD_DISABLED;
        endcase
        // Host-side emulator reset returns defaults
        if (emu_rst)
        begin
            next_emu_free = 1'b0;
            next_emu_soft = 1'b0;
            next_prd      = `RST_PRD;
            next_en_mode  = `EN_OFF;
            next_run_lo   = 1'b0;
            next_run_hi   = 1'b0;
            next_tmode    = `RST_MODE;
            next_wd_en    = 1'b0;
            next_wd_key   = `RST_KEY;
            next_armed    = 1'b0;
            next_state    = watchdog_pkg::WD_DISABLED;
            clear_cnt     = 1'b1;
        end
        next_idle_ack = idle_req && !wd_mode;
    end

    // Counter half controls
    always_comb
    begin
        lo_if.run      = run_lo;
        hi_if.run      = run_hi;
        lo_if.inc      = (gp_run || wd_run) && !match;
        hi_if.inc      = lo_if.carry;
        lo_if.clear    = clear_cnt;
        hi_if.clear    = clear_cnt;
        lo_if.load     = wr && (addr == `OFF_CNT_LO) && !locked;
        hi_if.load     = wr && (addr == `OFF_CNT_HI) && !locked;
        lo_if.load_val = wdata;
        hi_if.load_val = wdata;
    end

    // Read data mux
    always_comb
    begin
        rd_wdcr                     = `RST_WORD;
        rd_wdcr[`WD_EN_BIT]         = wd_en;
        rd_wdcr[`WD_KEY_LSB +: 16]  = wd_key;
        next_rdata                  = `RST_WORD;
        if (rd)
        begin
            case (addr)
                `OFF_EMU:    next_rdata = {30'h0, emu_soft, emu_free};
                `OFF_CNT_LO: next_rdata = count[31:0];
                `OFF_CNT_HI: next_rdata = count[63:32];
                `OFF_PRD_LO: next_rdata = prd[31:0];
                `OFF_PRD_HI: next_rdata = prd[63:32];
                `OFF_TCR:    next_rdata = {30'h0, en_mode};
                `OFF_GCR:    next_rdata = {28'h0, tmode, run_hi, run_lo};
                `OFF_WDCR:   next_rdata = rd_wdcr;
                default:     next_rdata = `RST_WORD;
            endcase
        end
    end

    // Registers, all at defaults after hardware reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            emu_free             <= 1'b0;
            emu_soft             <= 1'b0;
            prd                  <= `RST_PRD;
            en_mode              <= `EN_OFF;
            run_lo               <= 1'b0;
            run_hi               <= 1'b0;
            tmode                <= `RST_MODE;
            wd_en                <= 1'b0;
            wd_key               <= `RST_KEY;
            armed                <= 1'b0;
            state                <= watchdog_pkg::WD_DISABLED;
            rdata                <= `RST_WORD;
            timer_interrupt_line <= 1'b0;
            timer_dma_event      <= 1'b0;
            processor_reset_req  <= 1'b0;
            idle_ack             <= 1'b0;
        end
        else
        begin
            emu_free             <= next_emu_free;
            emu_soft             <= next_emu_soft;
            prd                  <= next_prd;
            en_mode              <= next_en_mode;
            run_lo               <= next_run_lo;
            run_hi               <= next_run_hi;
            tmode                <= next_tmode;
            wd_en                <= next_wd_en;
            wd_key               <= next_wd_key;
            armed                <= next_armed;
            state                <= next_state;
            rdata                <= next_rdata;
            timer_interrupt_line <= next_irq;
            timer_dma_event      <= next_dma;
            processor_reset_req  <= next_prst;
            idle_ack             <= next_idle_ack;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_key1;
        state == watchdog_pkg::WD_ACTIVE && wdcr_wr && wr_key == `KEY_FIRST;
    endsequence
    sequence s_key2;
        state == watchdog_pkg::WD_ACTIVE && wdcr_wr && wr_key == `KEY_SECOND && !match;
    endsequence

    property p_preactive_entry;
        $rose(state == watchdog_pkg::WD_PREACTIVE) |-> $past(wd_mode && wdcr_wr) && wd_en;
    endproperty
    a_preactive_entry: assert property (p_preactive_entry)
        else $error("pre-active entered without mode and key write");

    property p_match_timeout;
        wd_run && match |=> state == watchdog_pkg::WD_TIMEOUT && processor_reset_req;
    endproperty
    a_match_timeout: assert property (p_match_timeout)
        else $error("period match did not time out");

    property p_active_stays;
        state == watchdog_pkg::WD_ACTIVE |=>
            state == watchdog_pkg::WD_ACTIVE || state == watchdog_pkg::WD_TIMEOUT;
    endproperty
    a_active_stays: assert property (p_active_stays)
        else $error("active watchdog left without timeout");

    property p_bad_key;
        state == watchdog_pkg::WD_ACTIVE && wdcr_wr && !key_ok |=>
            state == watchdog_pkg::WD_TIMEOUT;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("bad key did not time out");

    property p_timeout_entry;
        $rose(state == watchdog_pkg::WD_TIMEOUT) |-> !wd_en && count == `RST_PRD;
    endproperty
    a_timeout_entry: assert property (p_timeout_entry)
        else $error("timeout did not clear enable and counter");

    property p_timeout_sticks;
        state == watchdog_pkg::WD_TIMEOUT |=> state == watchdog_pkg::WD_TIMEOUT && !wd_en;
    endproperty
    a_timeout_sticks: assert property (p_timeout_sticks)
        else $error("watchdog left timeout or re-enabled");

    property p_service;
        s_key1 ##1 !wdcr_wr ##1 s_key2 |=> count == `RST_PRD && state == watchdog_pkg::WD_ACTIVE;
    endproperty
    a_service: assert property (p_service)
        else $error("service sequence did not clear counter");

    property p_prd_locked;
        locked && wr && addr == `OFF_PRD_LO |=> $stable(prd);
    endproperty
    a_prd_locked: assert property (p_prd_locked)
        else $error("period written while protected");

    property p_no_wd_events;
        wd_mode |=> !timer_interrupt_line && !timer_dma_event;
    endproperty
    a_no_wd_events: assert property (p_no_wd_events)
        else $error("event raised in watchdog mode");

    property p_suspend_stop;
        susp && !emu_free && !emu_soft && !wr && !emu_reset_host |=> $stable(count);
    endproperty
    a_suspend_stop: assert property (p_suspend_stop)
        else $error("counter moved during hard suspend");

    property p_no_idle;
        wd_mode |=> !idle_ack;
    endproperty
    a_no_idle: assert property (p_no_idle)
        else $error("idle granted in watchdog mode");

    property p_run_hold;
        !run_lo && !lo_if.clear && !lo_if.load |=> $stable(count[31:0]);
    endproperty
    a_run_hold: assert property (p_run_hold)
        else $error("low half moved with run bit clear");

endmodule

// ===== core/keyed_watchdog_timer_consts.svh
// Purpose: Offsets, field positions, keys and reset values of the watchdog timer
// Assumes: Byte addresses on an 8-bit register port
// Notes:   Definitions only
`ifndef KEYED_WATCHDOG_TIMER_CONSTS_SVH
`define KEYED_WATCHDOG_TIMER_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFF_EMU     8'h04
`define OFF_CNT_LO  8'h10
`define OFF_CNT_HI  8'h14
`define OFF_PRD_LO  8'h18
`define OFF_PRD_HI  8'h1c
`define OFF_TCR     8'h20
`define OFF_GCR     8'h24
`define OFF_WDCR    8'h28

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EMU_FREE_BIT    0
`define EMU_SOFT_BIT    1
`define GCR_RUN_LO_BIT  0
`define GCR_RUN_HI_BIT  1
`define GCR_MODE_LSB    2
`define TCR_EN_LSB      0
`define WD_EN_BIT       14
`define WD_KEY_LSB      16

// ----------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------
`define KEY_FIRST       16'ha5c6
`define KEY_SECOND      16'hda7e
`define MODE_WATCHDOG   2'h2
`define EN_OFF          2'h0
`define EN_ONCE         2'h1
`define RST_MODE        2'h0
`define RST_KEY         16'h0000
`define RST_WORD        32'h0000_0000
`define RST_PRD         64'h0000_0000_0000_0000

`endif

// ===== core/watchdog_pkg.sv
// Purpose: Types shared by the watchdog timer files
// Assumes: Nothing
// Notes:   Used as watchdog_pkg::name
package watchdog_pkg;

    // Watchdog key state machine
    typedef enum logic [2:0] {
        WD_DISABLED  = 3'b000,
        WD_INITIAL   = 3'b001,
        WD_PREACTIVE = 3'b010,
        WD_ACTIVE    = 3'b011,
        WD_TIMEOUT   = 3'b100
    } wd_state_t;

endpackage

// ===== core/half_if.sv
// Purpose: Control and status of one 32-bit counter half
// Assumes: One controller, one counter half
// Notes:   Clear wins over load, load over increment
`timescale 1ns/1ns
interface half_if #(parameter int W = 32);
    logic         run;
    logic         inc;
    logic         clear;
    logic         load;
    logic [W-1:0] load_val;
    logic [W-1:0] value;
    logic         carry;

    modport ctrl (output run, inc, clear, load, load_val, input value, carry);
    modport half (input run, inc, clear, load, load_val, output value, carry);
endinterface

// ===== core/counter_half.sv
// Purpose: One counter half with run gate, clear, load and carry out
// Assumes: Controller drives the half_if ctrl side
// Notes:   Carry marks the wrap from all ones on a counting cycle
`timescale 1ns/1ns
module counter_half #(parameter int W = 32)
(
    input  wire logic clk,
    input  wire logic rst_b,
    half_if.half      hf
);

    logic [W-1:0] value;
    logic [W-1:0] next_value;

    // Next count
    always_comb
    begin
        next_value = value;
        if (hf.clear)
            next_value = {W{1'b0}};
        else if (hf.load)
            next_value = hf.load_val;
        else if (hf.run && hf.inc)
            next_value = W'(value + 1'b1);
    end

    // Count register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            value <= {W{1'b0}};
        else
            value <= next_value;
    end

    // Status back to the controller
    assign hf.value = value;
    assign hf.carry = hf.run && hf.inc && (&value);

endmodule

// ===== verification/keyed_watchdog_timer_tb_top.sv
// Purpose: Self-checking bench for the keyed watchdog timer
// Assumes: Register port with read data one cycle after the read strobe
// Notes:   Pulse outputs are counted by a monitor and compared as differences
`timescale 1ns/1ns
`include "keyed_watchdog_timer_consts.svh"
module keyed_watchdog_timer_tb_top;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        susp_host = 1'b0;
    logic        susp_dsp = 1'b0;
    logic        susp_src = 1'b0;
    logic        emu_reset_host = 1'b0;
    logic        idle_req = 1'b0;
    logic        idle_ack;
    logic        timer_interrupt_line;
    logic        timer_dma_event;
    logic        processor_reset_req;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          n_irq = 0;
    int          n_dma = 0;
    int          n_rst = 0;
    int          base_irq;
    int          base_dma;
    int          base_rst;
    logic [31:0] v1;
    logic [31:0] v2;

    keyed_watchdog_timer DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .susp_host(susp_host), .susp_dsp(susp_dsp),
        .suspend_source_select(susp_src), .emu_reset_host(emu_reset_host), .idle_req(idle_req),
        .idle_ack(idle_ack), .timer_interrupt_line(timer_interrupt_line),
        .timer_dma_event(timer_dma_event), .processor_reset_req(processor_reset_req));

    // --------------------------------------------------------------
    // Clock, pulse monitor and hang limit
    // --------------------------------------------------------------
    always #20 clk = ~clk;

    always @(negedge clk) // Mid-cycle, clear of the launch edge
    begin
        cyc = cyc + 1;
        if (timer_interrupt_line === 1'b1) n_irq = n_irq + 1;
        if (timer_dma_event === 1'b1) n_dma = n_dma + 1;
        if (processor_reset_req === 1'b1) n_rst = n_rst + 1;
        if (cyc == 5000)
        begin
            num_errors = num_errors + 1;
            report_and_stop();
        end
    end

    // --------------------------------------------------------------
    // Bus tasks and comparison
    // --------------------------------------------------------------
    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    task automatic chk_rd(input string name, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd_reg(a, d);
        check(name, e, d);
    endtask

    task automatic hw_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
    endtask

    task automatic arm_watchdog(input logic [31:0] prd);
        wr_reg(`OFF_PRD_LO, prd);
        wr_reg(`OFF_GCR, 32'h0000_000b);
        wr_reg(`OFF_WDCR, 32'ha5c6_4000);
        wr_reg(`OFF_WDCR, 32'h1234_4000);
        wr_reg(`OFF_WDCR, 32'hda7e_4000);
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial
    begin
        hw_reset();
        chk_rd("wdcr_reset", `OFF_WDCR, 32'h0000_0000);
        chk_rd("gcr_reset", `OFF_GCR, 32'h0000_0000);
        wr_reg(`OFF_PRD_LO, 32'h0000_0005);
        chk_rd("prd_lo_rw", `OFF_PRD_LO, 32'h0000_0005);
        wr_reg(`OFF_GCR, 32'h0000_0003);
        wr_reg(`OFF_TCR, 32'h0000_0002);
        base_irq = n_irq;
        base_dma = n_dma;
        repeat (61) @(posedge clk);
        check("irq_count", 32'd10, n_irq - base_irq);
        check("dma_count", 32'd10, n_dma - base_dma);
        susp_host <= 1'b1;
        rd_reg(`OFF_CNT_LO, v1);
        rd_reg(`OFF_CNT_LO, v2);
        check("susp_stop", v1, v2);
        susp_host <= 1'b0;
        susp_src  <= 1'b1;
        susp_dsp  <= 1'b1;
        rd_reg(`OFF_CNT_LO, v1);
        rd_reg(`OFF_CNT_LO, v2);
        check("susp_dsp_stop", v1, v2);
        wr_reg(`OFF_EMU, 32'h0000_0001);
        rd_reg(`OFF_CNT_LO, v1);
        rd_reg(`OFF_CNT_LO, v2);
        check("susp_free", 32'h0000_0001, {31'h0, v1 != v2});
        susp_dsp  <= 1'b0;
        wr_reg(`OFF_GCR, 32'h0000_0000);
        rd_reg(`OFF_CNT_LO, v1);
        rd_reg(`OFF_CNT_LO, v2);
        check("run_hold", v1, v2);
        idle_req <= 1'b1;
        repeat (2) @(posedge clk);
        check("idle_gp", 32'h1, {31'h0, idle_ack});
        idle_req <= 1'b0;
        @(posedge clk);
        emu_reset_host <= 1'b1;
        @(posedge clk);
        emu_reset_host <= 1'b0;
        chk_rd("emu_rst_prd", `OFF_PRD_LO, 32'h0000_0000);
        chk_rd("emu_rst_tcr", `OFF_TCR, 32'h0000_0000);

        // One-shot run: single event, count holds at period, enable drops
        wr_reg(`OFF_PRD_LO, 32'h0000_0003);
        wr_reg(`OFF_GCR, 32'h0000_0003);
        base_irq = n_irq;
        wr_reg(`OFF_TCR, 32'h0000_0001);
        repeat (20) @(posedge clk);
        check("once_irq", 32'd1, n_irq - base_irq);
        chk_rd("once_tcr", `OFF_TCR, 32'h0000_0000);
        chk_rd("once_hold", `OFF_CNT_LO, 32'h0000_0003);

        // Watchdog: bad key in pre-active ignored, then count-match timeout
        hw_reset();
        base_rst = n_rst;
        base_irq = n_irq;
        arm_watchdog(32'h0000_0028);
        check("prea_bad_key", 32'd0, n_rst - base_rst);
        wr_reg(`OFF_PRD_LO, 32'h0000_0007);
        chk_rd("prd_protect", `OFF_PRD_LO, 32'h0000_0028);
        wr_reg(`OFF_WDCR, 32'ha5c6_0000);
        chk_rd("watchdog_enable_bit_kept", `OFF_WDCR, 32'ha5c6_4000);
        idle_req <= 1'b1;
        repeat (2) @(posedge clk);
        check("idle_wd", 32'h0, {31'h0, idle_ack});
        idle_req <= 1'b0;
        repeat (20) @(posedge clk);
        wr_reg(`OFF_WDCR, 32'ha5c6_4000);
        wr_reg(`OFF_WDCR, 32'hda7e_4000);
        rd_reg(`OFF_CNT_LO, v1);
        check("service_clr", 32'h1, {31'h0, v1 < 32'd6});
        check("no_early_to", 32'd0, n_rst - base_rst);
        repeat (45) @(posedge clk);
        check("match_to", 32'd1, n_rst - base_rst);
        check("wd_no_irq", 32'd0, n_irq - base_irq);
        chk_rd("to_watchdog_enable_bit", `OFF_WDCR, 32'hda7e_0000);
        chk_rd("to_cnt", `OFF_CNT_LO, 32'h0000_0000);
        wr_reg(`OFF_WDCR, 32'ha5c6_4000);
        chk_rd("to_no_reen", `OFF_WDCR, 32'hda7e_0000);

        // Wrong key while active times out at once
        hw_reset();
        arm_watchdog(32'h0000_0200);
        base_rst = n_rst;
        wr_reg(`OFF_WDCR, 32'h1234_4000);
        @(posedge clk);
        check("bad_key_to", 32'd1, n_rst - base_rst);
        report_and_stop();
    end
endmodule
